// [dv/dcc_chan_tb.sv]
// Self-checking bench for the diskette channel host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			num_errors++; \
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp); \
		end \
	end
module dcc_chan_tb
	import dcc_pkg::*;
;
	logic clk, rst, rd_n, wr_n, idx, ak, doe, ackn, ackoe, irq, mreq, mack, t0, idv, hl, stp, sdir;
	logic [7:0] addr_n, wdat_n, skew, rv, dout, mdat, idt;
	logic [15:0] maddr;
	logic [4:0] port_a, sw;
	logic [1:0] dsel;
	logic [3:0] drv;
	int num_errors, num_checks;
	wire logic ack_w;
	assign ack_w = ackoe ? ackn : 1'b1;
	dcc_chan dcc_chan_i (.ref_clk_in(clk), .sys_rst_in(rst), .io_read_strobe_n_in(rd_n),
		.io_write_strobe_n_in(wr_n), .port_addr_n_in(addr_n), .bus_data_n_in(wdat_n),
		.bus_data_n_out(dout), .bus_data_oe_out(doe), .transfer_ack_n_out(ackn),
		.transfer_ack_oe_out(ackoe), .port_a_switch_in(sw), .int_req_out(irq),
		.mem_req_out(mreq), .mem_addr_out(maddr), .mem_ack_in(mack), .mem_data_in(mdat),
		.drive_ready_in(drv), .index_in(idx), .track0_in(t0), .id_valid_in(idv),
		.id_track_in(idt), .drive_sel_out(dsel), .head_load_out(hl), .step_out(stp),
		.step_dir_out(sdir));
	dcc_far dcc_far_i (.clk_in(clk), .rst_in(rst), .req_in(mreq), .addr_in(maddr),
		.ack_out(mack), .data_out(mdat), .step_in(stp), .dir_in(sdir), .skew_in(skew),
		.trk0_out(t0), .id_out(idv), .id_trk_out(idt));
	function automatic logic [7:0] stat(input logic i);
		return {1'b0, drv[3:2], 2'b11, i, drv[1:0]};
	endfunction
	// Holds the strobe until acknowledge or the limit, then idles two cycles
	task automatic bus(input logic w, input logic [2:0] p, input logic [7:0] d, input int lim);
		int n;
		n = 0;
		addr_n <= ~{port_a, p};
		wdat_n <= ~d;
		wr_n <= !w;
		rd_n <= w;
		@(posedge clk);
		while (ack_w !== 1'b0 && n < lim) begin
			@(posedge clk);
			n++;
		end
		ak = (ack_w === 1'b0);
		rv = ~(doe ? dout : 8'hFF);
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic start(input logic [7:0] cw, input logic [7:0] ins, input logic [7:0] t);
		dcc_far_i.mem[8'h40] = cw;
		dcc_far_i.mem[8'h41] = ins;
		dcc_far_i.mem[8'h43] = t;
		bus(1'b1, WR_PTR_LO, 8'h40, ACK_IO_MAX_CYC);
		`CHK(ak, 1'b1)
		bus(1'b1, WR_PTR_HI, 8'h00, ACK_IO_MAX_CYC);
		`CHK(ak, 1'b1)
	endtask
	// Polls status until the interrupt flop shows, then fetches the result
	task automatic finish(input logic en, input logic [1:0] rt, input logic [7:0] rb);
		int n;
		n = 0;
		rv = 8'h00;
		while (rv[ST_IRQ] !== 1'b1 && n < 400) begin
			repeat (20) @(posedge clk);
			bus(1'b0, RD_STATUS, 8'h00, ACK_STAT_MAX_CYC);
			n++;
		end
		`CHK(rv, stat(1'b1))
		`CHK(irq, en)
		bus(1'b0, RD_TYPE, 8'h00, ACK_STAT_MAX_CYC);
		`CHK(rv[1:0], rt)
		bus(1'b0, RD_RESULT, 8'h00, ACK_IO_MAX_CYC);
		`CHK(rv, rb)
	endtask
	task automatic pulse();
		idx <= 1'b1;
		repeat (3) @(posedge clk);
		idx <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("Checks: %0d, errors: %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		complete_run();
	end
	initial begin
		rst = 1'b1;
		{rd_n, wr_n, addr_n, wdat_n} = 18'h3_FFFF;
		{port_a, sw, drv, idx, skew} = {5'h0A, 5'h0A, 4'h0, 1'b0, 8'h00};
		for (int i = 0; i < 256; i++) begin
			dcc_far_i.mem[i] = 8'h00;
		end
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, RD_STATUS, 8'h00, ACK_STAT_MAX_CYC);
		`CHK(rv, stat(1'b0))
		// Undefined ports and a foreign port_a stay silent
		for (int p = 0; p < 8; p++) begin
			if (p == 2 || p > 3) begin
				bus(1'b0, 3'(p), 8'h00, 20);
				`CHK(ak, 1'b0)
				`CHK(rv, 8'h00)
			end
			if (p == 0 || (p > 2 && p < 7)) begin
				bus(1'b1, 3'(p), 8'hFF, 20);
				`CHK(ak, 1'b0)
			end
		end
		sw <= 5'h0B;
		bus(1'b0, RD_STATUS, 8'h00, 20);
		`CHK(ak, 1'b0)
		sw <= 5'h0A;
		drv <= 4'h5;
		finish(1'b1, RT_READY, 8'h05);
		bus(1'b0, RD_STATUS, 8'h00, ACK_STAT_MAX_CYC);
		`CHK(rv, stat(1'b0))
		start(8'h00, {5'h00, OPC_RECAL}, 8'h00);
		finish(1'b1, RT_DONE, ERR_NONE);
		`CHK(t0, 1'b1)
		// Busy seek on unit 1: refusals, then drive 0 bounces
		start(8'h00, {5'h02, OPC_SEEK}, 8'h05);
		bus(1'b1, WR_PTR_LO, 8'h40, 100);
		`CHK(ak, 1'b0)
		bus(1'b1, WR_PTR_HI, 8'h00, 100);
		`CHK(ak, 1'b0)
		bus(1'b0, RD_RESULT, 8'h00, 100);
		`CHK(ak, 1'b0)
		bus(1'b0, RD_TYPE, 8'h00, ACK_STAT_MAX_CYC);
		`CHK(ak, 1'b1)
		`CHK(dsel, 2'h1)
		drv <= 4'h4;
		repeat (10) @(posedge clk);
		drv <= 4'h5;
		finish(1'b1, RT_DONE, ERR_NONE);
		finish(1'b1, RT_READY, 8'h04);
		finish(1'b1, RT_READY, 8'h05);
		repeat (5) pulse();
		`CHK(hl, 1'b1)
		pulse();
		`CHK(hl, 1'b0)
		skew <= 8'h01;
		start(8'h00, {5'h02, OPC_SEEK}, 8'h02);
		finish(1'b1, RT_DONE, ERR_SEEK);
		skew <= 8'h00;
		start(8'h10, 8'h04, 8'h00);
		finish(1'b0, RT_DONE, ERR_NONE);
		// Reset during the seek's parameter fetch is taken at once and leaves the channel idle
		start(8'h00, {5'h02, OPC_SEEK}, 8'h0A);
		bus(1'b1, WR_RESET, 8'hA5, ACK_IO_MAX_CYC);
		`CHK(ak, 1'b1)
		bus(1'b1, WR_PTR_LO, 8'h40, ACK_IO_MAX_CYC);
		`CHK(ak, 1'b1)
		complete_run();
	end
endmodule
`default_nettype wire

// [dv/dcc_far.sv]
// Far-side model: system memory holding parameter blocks, and a drive mechanism
`timescale 1ns/1ps
`default_nettype none
module dcc_far
	import dcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Memory port
	input wire logic req_in,
	input wire logic [15:0] addr_in,
	output logic ack_out,
	output logic [7:0] data_out,
	// Drive
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic [7:0] skew_in,
	output logic trk0_out,
	output logic id_out,
	output logic [7:0] id_trk_out
);
	logic [7:0] mem [0:255];
	logic [7:0] trk;
	logic [8:0] cnt;
	assign trk0_out = (trk == 8'h00);
	// -------------------------------
	// Memory
	// -------------------------------
	// An idle cycle between answers gives the address time to advance
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_out <= 1'b0;
			data_out <= 8'h00;
		end else begin
			ack_out <= req_in && !ack_out;
			// Released lines toggle so stale data is never mistaken for valid
			data_out <= (req_in && !ack_out) ? mem[addr_in[7:0]] : ~data_out;
		end
	end
	// -------------------------------
	// Head and track read-back
	// -------------------------------
	// Head starts off track zero so a recalibrate must really step
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			trk <= 8'h03;
			cnt <= 9'h000;
			id_out <= 1'b0;
			id_trk_out <= 8'h00;
		end else begin
			if (step_in) begin
				trk <= dir_in ? trk + 8'h01 : (trk == 8'h00 ? trk : trk - 8'h01);
			end
			cnt <= (cnt == 9'h12B) ? 9'h000 : cnt + 9'h001;
			id_out <= (cnt == 9'h12B);
			id_trk_out <= (cnt == 9'h12B) ? trk + skew_in : ~id_trk_out;
		end
	end
endmodule
`default_nettype wire

// [src/dcc_chan.sv]
// Diskette channel host command port, sequencer and result logic
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Decode commands from read/write strobes and low three address bits; port_a match on upper five.
// R2: Host drives write strobe, duplicated port address and write data until acknowledged.
// R3: Host keeps write data stable until acknowledge returns.
// R4: Read data is on the bus before acknowledge is asserted.
// R5: Output commands are acknowledged within 3 us when idle.
// R6: Pointer writes while busy get no acknowledge; host bus timeout ends them.
// R7: Reset command is always acknowledged and clears control logic at once.
// R8: Status and result-type reads acknowledged within 1 us, busy or not.
// R9: Status always valid; result type meaningful only after an interrupt.
// R10: Result-byte read acknowledged within 3 us when idle, ignored when busy.
// R11: Host reads result type then result byte, only after interrupt.
// R12: Write at offset one loads pointer low byte.
// R13: Write at offset two loads pointer high byte and starts the operation.
// R14: Write at offset seven resets all control logic, data ignored. The interrupt enable and last reported ready bits keep their values.
// R15: Status holds drive ready bits, interrupt flop, presence flags at fixed positions.
// R16: Two low result-type bits select the result-byte kind.
// R17: Type code 10 returns current ready state of each drive.
// R18: Drive dropping then returning while busy yields not-ready then ready reports.
// R19: After start, fetch parameter block, decode, perform, set interrupt flop.
// R20: After result-byte read, count six index pulses, then unload head.
// R21: Recalibrate steps to track zero, judged by track-zero sensor.
// R22: Seek moves to target track, reads track from media, mismatch is error.
// R23: Host prepares a seven byte parameter block before starting.
// R24: Channel word bits 4 and 5 enable or disable interrupt requests.
// R25: Undefined command ports are neither acknowledged nor driven.
module dcc_chan
	import dcc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Host I/O bus; strobes, address, data and acknowledge active low, enables and interrupt active high
	input wire logic io_read_strobe_n_in,
	input wire logic io_write_strobe_n_in,
	input wire logic [7:0] port_addr_n_in,
	input wire logic [7:0] bus_data_n_in,
	output logic [7:0] bus_data_n_out,
	output logic bus_data_oe_out,
	output logic transfer_ack_n_out,
	output logic transfer_ack_oe_out,
	input wire logic [4:0] port_a_switch_in,
	output logic int_req_out,
	// Memory fetch port
	output logic mem_req_out,
	output logic [15:0] mem_addr_out,
	input wire logic mem_ack_in,
	input wire logic [7:0] mem_data_in,
	// Drive side
	input wire logic [3:0] drive_ready_in,
	input wire logic index_in,
	input wire logic track0_in,
	input wire logic id_valid_in,
	input wire logic [7:0] id_track_in,
	output logic [1:0] drive_sel_out,
	output logic head_load_out,
	output logic step_out,
	output logic step_dir_out
);
	localparam int LAT = 32'(ACK_LAT_CYC);
	localparam int IO_MAX = ACK_IO_MAX_CYC;
	localparam int ST_MAX = ACK_STAT_MAX_CYC;

	dcc_op_if op_if();
	dcc_ack_e ak_reg;
	dcc_seq_e seq_reg;
	logic [3:0] ak_cnt_reg;
	logic [7:0] rd_data_reg;
	logic rd_reg;
	logic [15:0] ptr_reg;
	logic [7:0] pb_reg [PB_LEN];
	logic [2:0] idx_reg;
	logic [1:0] res_type_reg;
	logic [7:0] res_byte_reg;
	logic res_pend_reg;
	logic irq_ff_reg;
	logic irq_en_reg;
	logic [3:0] rep_reg;
	logic [3:0] drop_reg;
	logic [3:0] drop_next;
	logic arm_reg;
	logic [2:0] hcnt_reg;
	logic index_prev_reg;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	logic [7:0] adr;
	logic [7:0] wdata;
	logic rd;
	logic wr;
	logic hit;
	logic is_ptr;
	logic is_rst;
	logic is_st;
	logic is_ty;
	logic is_rb;
	logic valid;
	logic busy;
	logic take;
	logic start;
	logic soft_clr;
	logic ack_on;
	logic is_move;
	logic fin;
	logic rc_fire;
	logic idx_edge;
	logic [7:0] status;

	assign adr = ~port_addr_n_in;
	assign wdata = ~bus_data_n_in;
	assign rd = ~io_read_strobe_n_in & io_write_strobe_n_in;
	assign wr = ~io_write_strobe_n_in & io_read_strobe_n_in;
	assign hit = adr[7:3] == port_a_switch_in; // R1
	assign is_ptr = wr & (adr[2:0] == WR_PTR_LO || adr[2:0] == WR_PTR_HI);
	assign is_rst = wr & (adr[2:0] == WR_RESET);
	assign is_st = rd & (adr[2:0] == RD_STATUS);
	assign is_ty = rd & (adr[2:0] == RD_TYPE);
	assign is_rb = rd & (adr[2:0] == RD_RESULT);
	assign valid = hit & (is_ptr | is_rst | is_st | is_ty | is_rb); // R25
	assign busy = seq_reg != SQ_IDLE;
	// Busy channel drops pointer writes and result reads on the floor
	assign take = (ak_reg == AK_IDLE) & valid & ~(busy & (is_ptr | is_rb)); // R6 R10
	assign start = take & is_ptr & (adr[2:0] == WR_PTR_HI); // R13
	assign soft_clr = take & is_rst; // R7 R14
	assign ack_on = ak_reg == AK_HOLD;
	assign transfer_ack_n_out = ~ack_on;
	assign transfer_ack_oe_out = ack_on;
	assign bus_data_n_out = ~rd_data_reg;
	assign bus_data_oe_out = rd_reg & (ak_reg == AK_WAIT || ak_reg == AK_HOLD); // R4
	assign int_req_out = irq_ff_reg & irq_en_reg; // R24
	// Drive 3, drive 2, double density, present, interrupt, drive 1, drive 0
	assign status = {1'b0, drive_ready_in[3:2], 1'b1, 1'b1, irq_ff_reg, drive_ready_in[1:0]}; // R15

	// ------------------------------------------------------------------
	// Acknowledge handshake
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ak_reg <= AK_IDLE;
			ak_cnt_reg <= 4'h0;
		end else begin
			case (ak_reg)
				AK_IDLE: begin
					ak_cnt_reg <= 4'h1;
					if (take) begin
						ak_reg <= AK_WAIT;
					end else if (valid) begin
						ak_reg <= AK_IGN;
					end
				end
				AK_WAIT: begin
					if (!(rd | wr)) begin
						ak_reg <= AK_IDLE;
					end else if (ak_cnt_reg == ACK_LAT_CYC - 4'h1) begin
						ak_reg <= AK_HOLD; // R5 R8 R10
					end else begin
						ak_cnt_reg <= ak_cnt_reg + 4'h1;
					end
				end
				AK_HOLD, AK_IGN: begin
					if (!(rd | wr)) begin
						ak_reg <= AK_IDLE;
					end
				end
				default: ak_reg <= AK_IDLE;
			endcase
		end
	end

	// Read data is captured at the request so it settles before acknowledge
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_data_reg <= 8'h00;
			rd_reg <= 1'b0;
		end else if (take) begin
			rd_reg <= rd;
			if (is_st) begin
				rd_data_reg <= status; // R9
			end else if (is_ty) begin
				rd_data_reg <= {6'h00, res_type_reg}; // R16
			end else if (is_rb) begin
				rd_data_reg <= res_byte_reg;
			end else begin
				rd_data_reg <= 8'h00;
			end
		end else if (ak_reg == AK_IDLE) begin
			rd_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Pointer and parameter block fetch
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ptr_reg <= 16'h0000;
		end else if (soft_clr) begin
			ptr_reg <= 16'h0000;
		end else if (take & is_ptr & (adr[2:0] == WR_PTR_LO)) begin
			ptr_reg[7:0] <= wdata; // R12
		end else if (start) begin
			ptr_reg[15:8] <= wdata; // R13
		end
	end

	assign is_move = pb_reg[PB_INSTR][2:0] == OPC_RECAL || pb_reg[PB_INSTR][2:0] == OPC_SEEK;
	// Other operations complete at once; their media handling lives elsewhere
	assign fin = (seq_reg == SQ_EXEC) & (~is_move | op_if.done);
	assign op_if.start = (seq_reg == SQ_FETCH) & mem_ack_in & (idx_reg == PB_LAST) & is_move;
	assign op_if.recal = pb_reg[PB_INSTR][2:0] == OPC_RECAL; // R21
	assign op_if.target = pb_reg[PB_TRACK]; // R22
	assign op_if.abort = soft_clr;
	assign mem_req_out = seq_reg == SQ_FETCH;
	assign drive_sel_out = pb_reg[PB_INSTR][IN_UNIT_LO +: 2];

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			seq_reg <= SQ_IDLE;
			idx_reg <= 3'h0;
			mem_addr_out <= 16'h0000;
		end else if (soft_clr) begin
			seq_reg <= SQ_IDLE;
			idx_reg <= 3'h0;
		end else begin
			case (seq_reg)
				SQ_IDLE: begin
					if (start) begin
						seq_reg <= SQ_FETCH; // R19
						idx_reg <= 3'h0;
						mem_addr_out <= {wdata, ptr_reg[7:0]};
					end
				end
				SQ_FETCH: begin
					if (mem_ack_in) begin
						idx_reg <= idx_reg + 3'h1;
						mem_addr_out <= mem_addr_out + 16'h0001;
						if (idx_reg == PB_LAST) begin
							seq_reg <= SQ_EXEC;
						end
					end
				end
				SQ_EXEC: begin
					if (fin) begin
						seq_reg <= SQ_IDLE;
					end
				end
				default: seq_reg <= SQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (seq_reg == SQ_FETCH && mem_ack_in) begin
			pb_reg[idx_reg] <= mem_data_in;
		end
	end

	dcc_op dcc_op_i (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.op_if(op_if),
		.track0_in(track0_in),
		.id_valid_in(id_valid_in),
		.id_track_in(id_track_in),
		.step_out(step_out),
		.step_dir_out(step_dir_out)
	);

	// ------------------------------------------------------------------
	// Results, interrupt flip-flop and ready change tracking
	// ------------------------------------------------------------------
	// Ready changes wait until the previous result has been read out
	assign rc_fire = ~busy & ~res_pend_reg & ~start & ((|drop_reg) | (rep_reg != drive_ready_in));
	// A drive that drops while busy is remembered even if it returns
	assign drop_next = rc_fire ? 4'h0 : (drop_reg | (busy ? (rep_reg & ~drive_ready_in) : 4'h0));

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			res_type_reg <= RT_DONE;
			res_byte_reg <= ERR_NONE;
			rep_reg <= 4'h0;
			drop_reg <= 4'h0;
			irq_en_reg <= 1'b1;
		end else if (soft_clr) begin
			res_type_reg <= RT_DONE;
			res_byte_reg <= ERR_NONE;
			drop_reg <= 4'h0;
		end else begin
			drop_reg <= drop_next; // R18
			if (fin) begin
				res_type_reg <= RT_DONE;
				res_byte_reg <= is_move ? op_if.err : ERR_NONE;
				irq_en_reg <= pb_reg[PB_CHAN][CW_IC_LO +: 2] == IC_ON; // R24
			end else if (rc_fire) begin
				res_type_reg <= RT_READY; // R17
				res_byte_reg <= {4'h0, drive_ready_in & ~drop_reg};
				rep_reg <= drive_ready_in & ~drop_reg; // R18
			end
		end
	end

	// Hardware set wins over the clearing read in the same cycle
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_ff_reg <= 1'b0;
			res_pend_reg <= 1'b0;
		end else if (soft_clr) begin
			irq_ff_reg <= 1'b0;
			res_pend_reg <= 1'b0;
		end else begin
			if (fin | rc_fire) begin
				irq_ff_reg <= 1'b1; // R19
				res_pend_reg <= 1'b1;
			end else begin
				if (take & is_ty) begin
					irq_ff_reg <= 1'b0;
				end
				if (take & is_rb) begin
					res_pend_reg <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Head unload after index count
	// ------------------------------------------------------------------
	assign idx_edge = index_in & ~index_prev_reg;

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			head_load_out <= 1'b0;
			arm_reg <= 1'b0;
			hcnt_reg <= 3'h0;
			index_prev_reg <= 1'b0;
		end else if (soft_clr) begin
			head_load_out <= 1'b0;
			arm_reg <= 1'b0;
			hcnt_reg <= 3'h0;
		end else begin
			index_prev_reg <= index_in;
			if (start) begin
				head_load_out <= 1'b1;
				arm_reg <= 1'b0;
				hcnt_reg <= 3'h0;
			end else if (take & is_rb) begin
				arm_reg <= 1'b1;
				hcnt_reg <= 3'h0;
			end else if (arm_reg & idx_edge) begin
				if (hcnt_reg == HEAD_IDX - 3'h1) begin
					head_load_out <= 1'b0; // R20
					arm_reg <= 1'b0;
					hcnt_reg <= 3'h0;
				end else begin
					hcnt_reg <= hcnt_reg + 3'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	AST_ACK_ONLY_DECODED: assert property ($rose(ack_on) |-> valid) // R1
		else $error("acknowledge for an undecoded port");
	AST_UNDEF_SILENT: assert property ((ak_reg == AK_IDLE && !valid) |=> !bus_data_oe_out) // R25
		else $error("data driven for undefined port");
	AST_OUT_ACK_TIME: assert property ((take && wr) |-> ##[1:IO_MAX] (ack_on || !wr)) // R5
		else $error("output command not acknowledged in time");
	AST_STAT_ACK_TIME: assert property ((take && (is_st || is_ty)) |-> ##[1:ST_MAX] (ack_on || !rd)) // R8
		else $error("status read not acknowledged in time");
	AST_BUSY_IGNORE: assert property ((ak_reg == AK_IDLE && busy && hit && (is_ptr || is_rb))
		|=> (!ack_on && ak_reg == AK_IGN)) // R6
		else $error("busy channel acknowledged a pointer or result access");
	AST_DATA_FIRST: assert property (($rose(ack_on) && rd_reg) |-> $past(bus_data_oe_out)) // R4
		else $error("acknowledge before read data");
	AST_RESET_NOW: assert property (soft_clr |=> (seq_reg == SQ_IDLE && !irq_ff_reg && ak_reg == AK_WAIT)) // R7
		else $error("reset command not executed");
	AST_START_FETCH: assert property (start |=> (mem_req_out && mem_addr_out == {ptr_reg[15:8], ptr_reg[7:0]})) // R13
		else $error("start did not fetch at pointer");
	AST_IRQ_ON_DONE: assert property ((fin && !soft_clr) |=> (irq_ff_reg && res_type_reg == RT_DONE)) // R19
		else $error("interrupt flop not set on completion");
	AST_READY_REPORT: assert property ((rc_fire && !soft_clr) |=> (res_type_reg == RT_READY && res_pend_reg)) // R17
		else $error("ready change not reported");
	AST_HEAD_UNLOAD: assert property ((arm_reg && idx_edge && hcnt_reg == HEAD_IDX - 3'h1 && !start
		&& !soft_clr && !(take && is_rb)) |=> !head_load_out) // R20
		else $error("head not unloaded after index count");

	COV_SEEK_DONE: cover property (fin && op_if.recal == 1'b0 && is_move);
	COV_READY_CHANGE: cover property (rc_fire);
	COV_BUSY_IGNORE: cover property (ak_reg == AK_IGN);
	COV_UNLOAD: cover property ($fell(head_load_out));
endmodule
`default_nettype wire

// [src/dcc_op.sv]
// Head positioner: recalibrate and seek
`timescale 1ns/1ps
`default_nettype none
module dcc_op
	import dcc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Sequencer side
	dcc_op_if.op op_if,
	// Drive side
	input wire logic track0_in,
	input wire logic id_valid_in,
	input wire logic [7:0] id_track_in,
	output logic step_out,
	output logic step_dir_out
);
	dcc_op_e st_reg;
	logic [7:0] cur_reg;
	logic [7:0] tgt_reg;
	logic [7:0] nstep_reg;
	logic [15:0] gap_reg;
	logic recal_reg;
	logic done_reg;
	logic [7:0] err_reg;

	assign op_if.done = done_reg;
	assign op_if.err = err_reg;

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_reg <= OP_IDLE;
			cur_reg <= 8'h00;
			tgt_reg <= 8'h00;
			nstep_reg <= 8'h00;
			gap_reg <= 16'h0000;
			recal_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= ERR_NONE;
			step_out <= 1'b0;
			step_dir_out <= 1'b0;
		end else if (op_if.abort) begin
			st_reg <= OP_IDLE;
			done_reg <= 1'b0;
			step_out <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			step_out <= 1'b0;
			case (st_reg)
				OP_IDLE: begin
					if (op_if.start) begin
						tgt_reg <= op_if.target;
						recal_reg <= op_if.recal;
						nstep_reg <= 8'h00;
						st_reg <= OP_MOVE;
					end
				end
				OP_MOVE: begin
					gap_reg <= 16'h0000;
					if (recal_reg) begin
						// Success is judged only from the track-zero sensor
						if (track0_in) begin
							cur_reg <= 8'h00;
							done_reg <= 1'b1;
							err_reg <= ERR_NONE;
							st_reg <= OP_IDLE;
						end else if (nstep_reg == RECAL_LIMIT) begin
							done_reg <= 1'b1;
							err_reg <= ERR_RECAL;
							st_reg <= OP_IDLE;
						end else begin
							step_out <= 1'b1;
							step_dir_out <= 1'b0;
							nstep_reg <= nstep_reg + 8'h01;
							st_reg <= OP_GAP;
						end // R21
					end else if (cur_reg == tgt_reg) begin
						st_reg <= OP_VERIFY;
					end else begin
						step_out <= 1'b1;
						step_dir_out <= tgt_reg > cur_reg;
						cur_reg <= (tgt_reg > cur_reg) ? cur_reg + 8'h01 : cur_reg - 8'h01;
						st_reg <= OP_GAP;
					end
				end
				OP_GAP: begin
					// Step rate limit of the drive mechanism
					if (gap_reg == STEP_CYC - 16'h0001) begin
						st_reg <= OP_MOVE;
					end else begin
						gap_reg <= gap_reg + 16'h0001;
					end
				end
				OP_VERIFY: begin
					if (id_valid_in) begin
						done_reg <= 1'b1;
						err_reg <= (id_track_in == tgt_reg) ? ERR_NONE : ERR_SEEK; // R22
						st_reg <= OP_IDLE;
					end
				end
				default: st_reg <= OP_IDLE;
			endcase
		end
	end

	AST_SEEK_MISMATCH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(st_reg == OP_VERIFY && id_valid_in && !op_if.abort && id_track_in != tgt_reg)
		|=> (done_reg && err_reg == ERR_SEEK)) // R22
		else $error("seek mismatch not reported");
	AST_RECAL_T0: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(st_reg == OP_MOVE && recal_reg && track0_in && !op_if.abort)
		|=> (done_reg && err_reg == ERR_NONE && cur_reg == 8'h00)) // R21
		else $error("recalibrate did not end at track zero");
endmodule
`default_nettype wire

// [src/dcc_op_if.sv]
// Link between the command sequencer and the head positioner
`timescale 1ns/1ps
`default_nettype none
interface dcc_op_if;
	logic start;
	logic recal;
	logic abort;
	logic done;
	logic [7:0] target;
	logic [7:0] err;
	modport seq(output start, recal, abort, target, input done, err);
	modport op(input start, recal, abort, target, output done, err);
endinterface
`default_nettype wire

// [src/dcc_pkg.sv]
// Constants, encodings and state types for the diskette channel host port
package dcc_pkg;
	// ------------------------------------------------------------------
	// Command ports (low three address bits)
	// ------------------------------------------------------------------
	localparam logic [2:0] RD_STATUS = 3'h0;
	localparam logic [2:0] RD_TYPE = 3'h1;
	localparam logic [2:0] RD_RESULT = 3'h3;
	localparam logic [2:0] WR_PTR_LO = 3'h1;
	localparam logic [2:0] WR_PTR_HI = 3'h2;
	localparam logic [2:0] WR_RESET = 3'h7;
	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_NS = 40;
	localparam int ACK_IO_NS = 3000;
	localparam int ACK_STAT_NS = 1000;
	localparam int ACK_IO_MAX_CYC = ACK_IO_NS / CLK_NS;
	localparam int ACK_STAT_MAX_CYC = ACK_STAT_NS / CLK_NS;
	localparam logic [3:0] ACK_LAT_CYC = 4'h2;
	localparam int STEP_US = 10;
	localparam logic [15:0] STEP_CYC = 16'(STEP_US * 1000 / CLK_NS);
	// ------------------------------------------------------------------
	// Parameter block layout
	// ------------------------------------------------------------------
	localparam int PB_LEN = 7;
	localparam logic [2:0] PB_LAST = 3'(PB_LEN - 1);
	localparam int PB_CHAN = 0;
	localparam int PB_INSTR = 1;
	localparam int PB_TRACK = 3;
	localparam int CW_IC_LO = 4;
	localparam logic [1:0] IC_ON = 2'h0;
	localparam int IN_UNIT_LO = 4;
	localparam logic [2:0] OPC_RECAL = 3'h3;
	localparam logic [2:0] OPC_SEEK = 3'h2;
	// ------------------------------------------------------------------
	// Status and result encodings
	// ------------------------------------------------------------------
	localparam int ST_IRQ = 2;
	localparam logic [1:0] RT_DONE = 2'h0;
	localparam logic [1:0] RT_READY = 2'h2;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_SEEK = 8'h02;
	localparam logic [7:0] ERR_RECAL = 8'h04;
	localparam logic [7:0] RECAL_LIMIT = 8'h50;
	localparam logic [2:0] HEAD_IDX = 3'h6;
	// ------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {AK_IDLE, AK_WAIT, AK_HOLD, AK_IGN} dcc_ack_e;
	typedef enum logic [1:0] {SQ_IDLE, SQ_FETCH, SQ_EXEC} dcc_seq_e;
	typedef enum logic [1:0] {OP_IDLE, OP_MOVE, OP_GAP, OP_VERIFY} dcc_op_e;
endpackage
